// *** verilog/slgb_pkg.sv ***
// constants and carrier types for the serial link gpio bridge
// How it works
// - in 18-bit mode the four low colour lanes become gpio, forward input or back output
// - bit 2 of register 0x12 selects 18-bit colour mode
// - the 18-bit setting travels to the remote end inside every forward frame
// - lane 3 uses register 0x0F low nibble, 0x03 forward input, 0x05 back output
// - lane 2 and lane 1 share 0x0E by nibble; lane 0 uses 0x0D low nibble
// - local pins 7 to 4, when outputs, are set only by local register bits
// - register 0x11 low nibble 0x9 drives local pin 7 high, 0x1 drives it low
// - pin 6 from 0x10 high nibble, pin 5 from 0x10 low, pin 4 from 0x0F high
// - bits 4 and 5 of 0x0F make local pin 4 an input forwarded to lane 0
// - bits 0 and 1 of 0x10 make local pin 5 an input forwarded to lane 1
// - back channel frames carry four gpio bits for back-output lanes
package slgb_pkg;

	localparam int unsigned NUM_LANES = 4;
	localparam int unsigned NUM_REGS  = 6;

	// register offsets
	localparam logic [7:0] ADDR_LANE0   = 8'h0d;
	localparam logic [7:0] ADDR_LANE12  = 8'h0e;
	localparam logic [7:0] ADDR_LANE3   = 8'h0f;
	localparam logic [7:0] ADDR_OUT56   = 8'h10;
	localparam logic [7:0] ADDR_OUT7    = 8'h11;
	localparam logic [7:0] ADDR_COLOUR  = 8'h12;

	// storage index of each register
	localparam logic [2:0] IDX_LANE0  = 3'h0;
	localparam logic [2:0] IDX_LANE12 = 3'h1;
	localparam logic [2:0] IDX_LANE3  = 3'h2;
	localparam logic [2:0] IDX_OUT56  = 3'h3;
	localparam logic [2:0] IDX_OUT7   = 3'h4;
	localparam logic [2:0] IDX_COLOUR = 3'h5;

	localparam logic [7:0] CFG_RESET  = 8'h00;
	localparam int unsigned MODE18_BIT = 2;

	// bit positions inside a four-bit configuration nibble
	localparam int unsigned NIB_EN  = 0;
	localparam int unsigned NIB_FWD = 1;
	localparam int unsigned NIB_BC  = 2;
	localparam int unsigned NIB_LVL = 3;

	// nibble codes used by software
	localparam logic [3:0] LANE_CFG_FWD = 4'h3;
	localparam logic [3:0] LANE_CFG_BC  = 4'h5;
	localparam logic [3:0] LOCAL_HIGH   = 4'h9;
	localparam logic [3:0] LOCAL_LOW    = 4'h1;

	// local pins that may turn into forwarded inputs (pins 4 and 5)
	localparam logic [3:0] LOCAL_IN_CAPABLE = 4'h3;

	typedef logic [NUM_REGS-1:0][7:0] slgb_cfg_t;

	typedef struct packed {
		logic       mode18;
		logic [3:0] gpio;
	} slgb_fwd_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] gpio;
	} slgb_bc_t;

endpackage

// *** verilog/slgb_cfg_mem.sv ***
// configuration storage with registered read port
module slgb_cfg_mem
	import slgb_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_idx,
	input  wire logic [7:0] wr_data,
	input  wire logic       rd_en,
	input  wire logic [2:0] rd_idx,
	output logic      [7:0] rd_data_reg,
	output slgb_cfg_t       cfg
);

	slgb_cfg_t  mem_reg;
	slgb_cfg_t  mem_next;
	logic [7:0] rd_data_next;

	assign cfg = mem_reg;

	////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_entry
			always_comb begin
				mem_next[g] = mem_reg[g];
				if (wr_en && wr_idx == 3'(g)) begin
					mem_next[g] = wr_data;
				end
			end
		end
	endgenerate

	// unmapped or idle reads return zero
	always_comb begin
		rd_data_next = 8'h00;
		if (rd_en && rd_idx < 3'(NUM_REGS)) begin
			rd_data_next = mem_reg[rd_idx];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mem_reg     <= {NUM_REGS{CFG_RESET}};
			rd_data_reg <= 8'h00;
		end else begin
			mem_reg     <= mem_next;
			rd_data_reg <= rd_data_next;
		end
	end

endmodule

// *** verilog/slgb_top.sv ***
// gpio bridge: lane direction, local outputs and link frame assembly
module slgb_top
	import slgb_pkg::*;
(
	input  wire logic       CORE_CLK,
	input  wire logic       RESET,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	output logic            REG_RVALID,
	input  wire logic [3:0] LANE_IN,
	output logic      [3:0] LANE_OUT,
	output logic      [3:0] LANE_OE,
	input  wire logic [1:0] LOCAL_IN,
	output logic      [3:0] LOCAL_OUT,
	output logic      [3:0] LOCAL_OE,
	output slgb_fwd_t       FWD_FRAME,
	input  wire slgb_bc_t   BC_FRAME
);

	slgb_cfg_t  cfg;
	logic       hit;
	logic [2:0] idx;
	logic       mode18;
	logic [3:0] lane_nib [NUM_LANES];
	logic [3:0] loc_nib  [NUM_LANES];
	logic [3:0] lane_fwd;
	logic [3:0] lane_bc;
	logic [3:0] loc_en;
	logic [3:0] loc_lvl;
	logic [3:0] loc_in;

	logic       rvalid_reg;
	logic       rvalid_next;
	logic [3:0] lane_out_reg;
	logic [3:0] lane_out_next;
	logic [3:0] lane_oe_reg;
	logic [3:0] lane_oe_next;
	logic [3:0] local_out_reg;
	logic [3:0] local_out_next;
	logic [3:0] local_oe_reg;
	logic [3:0] local_oe_next;
	slgb_fwd_t  fwd_reg;
	slgb_fwd_t  fwd_next;

	////////////////////////////////////////////////////////////////
	// register port decode
	always_comb begin
		hit = 1'b1;
		idx = IDX_LANE0;
		if (REG_ADDR == ADDR_LANE0) begin
			idx = IDX_LANE0;
		end else if (REG_ADDR == ADDR_LANE12) begin
			idx = IDX_LANE12;
		end else if (REG_ADDR == ADDR_LANE3) begin
			idx = IDX_LANE3;
		end else if (REG_ADDR == ADDR_OUT56) begin
			idx = IDX_OUT56;
		end else if (REG_ADDR == ADDR_OUT7) begin
			idx = IDX_OUT7;
		end else if (REG_ADDR == ADDR_COLOUR) begin
			idx = IDX_COLOUR;
		end else begin
			hit = 1'b0;
		end
	end

	slgb_cfg_mem u_cfg (
		.clk         (CORE_CLK),
		.rst         (RESET),
		.wr_en       (REG_WR && hit),
		.wr_idx      (idx),
		.wr_data     (REG_WDATA),
		.rd_en       (REG_RD && hit),
		.rd_idx      (idx),
		.rd_data_reg (REG_RDATA),
		.cfg         (cfg)
	);

	////////////////////////////////////////////////////////////////
	// field decode
	assign mode18 = cfg[IDX_COLOUR][MODE18_BIT];

	assign lane_nib[0] = cfg[IDX_LANE0][3:0];
	assign lane_nib[1] = cfg[IDX_LANE12][3:0];
	assign lane_nib[2] = cfg[IDX_LANE12][7:4];
	assign lane_nib[3] = cfg[IDX_LANE3][3:0];

	assign loc_nib[0] = cfg[IDX_LANE3][7:4];
	assign loc_nib[1] = cfg[IDX_OUT56][3:0];
	assign loc_nib[2] = cfg[IDX_OUT56][7:4];
	assign loc_nib[3] = cfg[IDX_OUT7][3:0];

	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : g_lane
			// gpio lanes only exist in 18-bit mode
			assign lane_fwd[g] = mode18 && lane_nib[g][NIB_EN]
				&& lane_nib[g][NIB_FWD] && !lane_nib[g][NIB_BC];
			assign lane_bc[g]  = mode18 && lane_nib[g][NIB_EN]
				&& lane_nib[g][NIB_BC] && !lane_nib[g][NIB_FWD];
			assign loc_en[g]   = mode18 && loc_nib[g][NIB_EN];
			assign loc_lvl[g]  = loc_nib[g][NIB_LVL];
			assign loc_in[g]   = mode18 && LOCAL_IN_CAPABLE[g]
				&& loc_nib[g][NIB_EN] && loc_nib[g][NIB_FWD];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// next values of pins and frames
	always_comb begin
		rvalid_next   = REG_RD;
		lane_oe_next  = lane_bc;
		lane_out_next = lane_out_reg;
		if (BC_FRAME.valid) begin
			lane_out_next = (BC_FRAME.gpio & lane_bc) | (lane_out_reg & ~lane_bc);
		end
		// local pins follow register bits only, link traffic never reaches them
		local_oe_next  = loc_en & ~loc_in;
		local_out_next = loc_lvl & local_oe_next;
		fwd_next.mode18 = mode18;
		fwd_next.gpio   = LANE_IN & lane_fwd;
		if (loc_in[0]) begin
			fwd_next.gpio[0] = LOCAL_IN[0];
		end
		if (loc_in[1]) begin
			fwd_next.gpio[1] = LOCAL_IN[1];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rvalid_reg    <= 1'b0;
			lane_out_reg  <= 4'h0;
			lane_oe_reg   <= 4'h0;
			local_out_reg <= 4'h0;
			local_oe_reg  <= 4'h0;
			fwd_reg       <= '0;
		end else begin
			rvalid_reg    <= rvalid_next;
			lane_out_reg  <= lane_out_next;
			lane_oe_reg   <= lane_oe_next;
			local_out_reg <= local_out_next;
			local_oe_reg  <= local_oe_next;
			fwd_reg       <= fwd_next;
		end
	end

	assign REG_RVALID = rvalid_reg;
	assign LANE_OUT   = lane_out_reg;
	assign LANE_OE    = lane_oe_reg;
	assign LOCAL_OUT  = local_out_reg;
	assign LOCAL_OE   = local_oe_reg;
	assign FWD_FRAME  = fwd_reg;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	a_mode18_follows_write: assert property (
		REG_WR && REG_ADDR == ADDR_COLOUR |-> ##2 FWD_FRAME.mode18 == $past(REG_WDATA[MODE18_BIT], 2))
		else $error("18-bit mode does not follow colour register write");

	a_mode_sent_forward: assert property (
		FWD_FRAME.mode18 == $past(mode18))
		else $error("forward frame mode flag differs from setting");

	a_lane_needs_mode: assert property (
		LANE_OE != 4'h0 |-> $past(mode18))
		else $error("gpio lane driven outside 18-bit mode");

	a_lane3_back_out: assert property (
		REG_WR && REG_ADDR == ADDR_LANE3 && REG_WDATA[3:0] == LANE_CFG_BC && mode18 |-> ##2 LANE_OE[3])
		else $error("lane 3 not driven after back output setting");

	a_lane0_forward: assert property (
		REG_WR && REG_ADDR == ADDR_LANE0 && REG_WDATA[3:0] == LANE_CFG_FWD && mode18 && !loc_in[0]
		|-> ##2 (FWD_FRAME.gpio[0] == $past(LANE_IN[0]) && !LANE_OE[0]))
		else $error("lane 0 not forwarded after forward input setting");

	a_local_stable: assert property (
		!REG_WR |-> ##2 ($stable(LOCAL_OUT) && $stable(LOCAL_OE)))
		else $error("local output moved without a register write");

	a_out7_high: assert property (
		REG_WR && REG_ADDR == ADDR_OUT7 && REG_WDATA[3:0] == LOCAL_HIGH && mode18
		|-> ##2 (LOCAL_OUT[3] && LOCAL_OE[3]))
		else $error("local pin 7 not high after write");

	a_out6_low: assert property (
		REG_WR && REG_ADDR == ADDR_OUT56 && REG_WDATA[7:4] == LOCAL_LOW && mode18
		|-> ##2 (!LOCAL_OUT[2] && LOCAL_OE[2]))
		else $error("local pin 6 not low after write");

	a_pin4_forward: assert property (
		loc_in[0] |=> (FWD_FRAME.gpio[0] == $past(LOCAL_IN[0]) && !LOCAL_OE[0]))
		else $error("local pin 4 level not forwarded to lane 0");

	a_pin5_forward: assert property (
		loc_in[1] |=> (FWD_FRAME.gpio[1] == $past(LOCAL_IN[1]) && !LOCAL_OE[1]))
		else $error("local pin 5 level not forwarded to lane 1");

	a_back_update: assert property (
		BC_FRAME.valid && lane_bc[2] |=> LANE_OUT[2] == $past(BC_FRAME.gpio[2]))
		else $error("back channel bit not driven on lane 2");

	a_back_hold: assert property (
		!BC_FRAME.valid |=> $stable(LANE_OUT))
		else $error("back output lane changed without a frame");

	////////////////////////////////////////////////////////////////
	// lane direction per configuration nibble
	a_idle_no_drive: assert property (
		!mode18 |=> (LANE_OE == 4'h0 && LOCAL_OE == 4'h0))
		else $error("pins driven outside 18-bit mode");

	a_idle_no_fwd: assert property (
		!FWD_FRAME.mode18 |-> FWD_FRAME.gpio == 4'h0)
		else $error("gpio bits forwarded outside 18-bit mode");

	a_upper_one_dir: assert property (
		(FWD_FRAME.gpio[3:2] & LANE_OE[3:2]) == 2'b00)
		else $error("driven lane also forwarded");

	a_lane3_forward: assert property (
		mode18 && cfg[IDX_LANE3][3:0] == LANE_CFG_FWD
		|=> (!LANE_OE[3] && FWD_FRAME.gpio[3] == $past(LANE_IN[3])))
		else $error("lane 3 not forwarded in forward input setting");

	a_lane3_no_fwd: assert property (
		mode18 && cfg[IDX_LANE3][3:0] == LANE_CFG_BC
		|=> (LANE_OE[3] && !FWD_FRAME.gpio[3]))
		else $error("lane 3 not a back output in back output setting");

	a_lane2_forward: assert property (
		mode18 && cfg[IDX_LANE12][7:4] == LANE_CFG_FWD
		|=> (!LANE_OE[2] && FWD_FRAME.gpio[2] == $past(LANE_IN[2])))
		else $error("lane 2 not forwarded in forward input setting");

	a_lane2_back: assert property (
		mode18 && cfg[IDX_LANE12][7:4] == LANE_CFG_BC
		|=> (LANE_OE[2] && !FWD_FRAME.gpio[2]))
		else $error("lane 2 not a back output in back output setting");

	a_lane1_forward: assert property (
		mode18 && cfg[IDX_LANE12][3:0] == LANE_CFG_FWD && !loc_in[1]
		|=> (!LANE_OE[1] && FWD_FRAME.gpio[1] == $past(LANE_IN[1])))
		else $error("lane 1 not forwarded in forward input setting");

	a_lane1_back: assert property (
		mode18 && cfg[IDX_LANE12][3:0] == LANE_CFG_BC |=> LANE_OE[1])
		else $error("lane 1 not a back output in back output setting");

	a_lane0_back: assert property (
		mode18 && cfg[IDX_LANE0][3:0] == LANE_CFG_BC |=> LANE_OE[0])
		else $error("lane 0 not a back output in back output setting");

	////////////////////////////////////////////////////////////////
	// local output levels
	a_out7_low: assert property (
		REG_WR && REG_ADDR == ADDR_OUT7 && REG_WDATA[3:0] == LOCAL_LOW && mode18
		|-> ##2 (!LOCAL_OUT[3] && LOCAL_OE[3]))
		else $error("local pin 7 not low after write");

	a_out6_high: assert property (
		REG_WR && REG_ADDR == ADDR_OUT56 && REG_WDATA[7:4] == LOCAL_HIGH && mode18
		|-> ##2 (LOCAL_OUT[2] && LOCAL_OE[2]))
		else $error("local pin 6 not high after write");

	a_out5_high: assert property (
		REG_WR && REG_ADDR == ADDR_OUT56 && REG_WDATA[3:0] == LOCAL_HIGH && mode18
		|-> ##2 (LOCAL_OUT[1] && LOCAL_OE[1]))
		else $error("local pin 5 not high after write");

	a_out5_low: assert property (
		REG_WR && REG_ADDR == ADDR_OUT56 && REG_WDATA[3:0] == LOCAL_LOW && mode18
		|-> ##2 (!LOCAL_OUT[1] && LOCAL_OE[1]))
		else $error("local pin 5 not low after write");

	a_out4_high: assert property (
		REG_WR && REG_ADDR == ADDR_LANE3 && REG_WDATA[7:4] == LOCAL_HIGH && mode18
		|-> ##2 (LOCAL_OUT[0] && LOCAL_OE[0]))
		else $error("local pin 4 not high after write");

	a_out4_low: assert property (
		REG_WR && REG_ADDR == ADDR_LANE3 && REG_WDATA[7:4] == LOCAL_LOW && mode18
		|-> ##2 (!LOCAL_OUT[0] && LOCAL_OE[0]))
		else $error("local pin 4 not low after write");

	a_level_needs_oe: assert property (
		(LOCAL_OUT & ~LOCAL_OE) == 4'h0)
		else $error("local level shown on an undriven pin");

	a_pin4_released: assert property (
		loc_in[0] |=> !LOCAL_OUT[0])
		else $error("local pin 4 driven while an input");

	a_pin5_released: assert property (
		loc_in[1] |=> !LOCAL_OUT[1])
		else $error("local pin 5 driven while an input");

	////////////////////////////////////////////////////////////////
	// back channel and forward sampling
	a_back_lanes: assert property (
		BC_FRAME.valid |=> (LANE_OUT & $past(lane_bc)) == ($past(BC_FRAME.gpio) & $past(lane_bc)))
		else $error("back channel bits not driven on back output lanes");

	a_back_others: assert property (
		BC_FRAME.valid |=> ((LANE_OUT ^ $past(LANE_OUT)) & ~$past(lane_bc)) == 4'h0)
		else $error("back channel frame moved a lane that is not a back output");

	a_fwd_sampled: assert property (
		FWD_FRAME.gpio[3:2] == ($past(LANE_IN[3:2]) & $past(lane_fwd[3:2])))
		else $error("forward lanes not sampled into the frame");

	c_mode18_on: cover property (REG_WR && REG_ADDR == ADDR_COLOUR && REG_WDATA[MODE18_BIT] ##2 FWD_FRAME.mode18);
	c_back_frame: cover property (BC_FRAME.valid && lane_bc != 4'h0 ##1 LANE_OE != 4'h0);
	c_out7_high: cover property (LOCAL_OUT[3]);
	c_pin4_fwd: cover property (loc_in[0] && LOCAL_IN[0] ##1 FWD_FRAME.gpio[0]);
	c_pin5_fwd: cover property (loc_in[1] && LOCAL_IN[1] ##1 FWD_FRAME.gpio[1]);

endmodule

// *** verification/slgb_remote_model.sv ***
// behavioural model of the remote deserializer across the link
module slgb_remote_model
	import slgb_pkg::*;
(
	input  wire logic            clk,
	input  wire slgb_fwd_t       fwd,
	input  wire logic [3:0][3:0] lane_cfg,
	input  wire logic [3:0]      rem_in,
	input  wire logic            send,
	output slgb_bc_t             bc,
	output logic      [3:0]      rem_out
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////
	always_ff @(negedge clk) begin
		for (int i = 0; i < 4; i++) begin
			rem_out[i] <= fwd.mode18 && lane_cfg[i][0] && lane_cfg[i][2] && fwd.gpio[i];
		end
		if (send) begin
			for (int i = 0; i < 4; i++) begin
				bc.gpio[i] <= rem_in[i] && lane_cfg[i][0] && lane_cfg[i][1];
			end
		end else begin
			// stale bits flip while no update is sent
			bc.gpio <= ~bc.gpio;
		end
		bc.valid <= send;
	end
endmodule

// *** verification/slgb_tb_top.sv ***
// self-checking bench for the serial link gpio bridge
module slgb_tb_top
	import slgb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic            clk, rst, wr_s, rd_s, rvalid, send;
	logic [7:0]      addr, wdata, rdata;
	logic [3:0]      lane_in, lane_out, lane_oe, local_out, local_oe, rem_in, rem_out;
	logic [1:0]      local_in;
	logic [3:0][3:0] rcfg;
	slgb_fwd_t       fwd;
	slgb_bc_t        bc;
	int              errors, checked;
	// addr, data, local level, local enable
	localparam logic [23:0] ROWS [8] = '{24'h110988, 24'h110108, 24'h10904c, 24'h10100c,
		24'h10092a, 24'h10010a, 24'h0f901b, 24'h0f100b};
	////////////////////////////////////////////////////////////////
	slgb_top dut (.CORE_CLK(clk), .RESET(rst), .REG_WR(wr_s), .REG_RD(rd_s), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .LANE_IN(lane_in),
		.LANE_OUT(lane_out), .LANE_OE(lane_oe), .LOCAL_IN(local_in), .LOCAL_OUT(local_out),
		.LOCAL_OE(local_oe), .FWD_FRAME(fwd), .BC_FRAME(bc));
	slgb_remote_model remote (.clk(clk), .fwd(fwd), .lane_cfg(rcfg), .rem_in(rem_in), .send(send),
		.bc(bc), .rem_out(rem_out));
	////////////////////////////////////////////////////////////////
	task automatic chk_reg(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_pin(string what, logic [4:0] exp, logic [4:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		wr_s = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr_s = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(negedge clk);
		rd_s = 1'b1;
		addr = a;
		@(negedge clk);
		rd_s = 1'b0;
		chk_reg("rvalid", 8'h01, {7'h00, rvalid});
		chk_reg("rdata", exp, rdata);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		{wr_s, rd_s, send, addr, wdata, lane_in, local_in, rem_in} = '0;
		rcfg = '0;
		errors = 0;
		checked = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(8'h0d + 8'(i), 8'h00);
		end
		rd(8'h20, 8'h00);
		$display("test register reads done");
		wr(ADDR_COLOUR, 8'h04);
		chk_pin("mode18", 5'h10, fwd);
		for (int i = 0; i < 8; i++) begin
			wr(ROWS[i][23:16], ROWS[i][15:8]);
			chk_pin("local_out", {1'b0, ROWS[i][7:4]}, {1'b0, local_out});
			chk_pin("local_oe", {1'b0, ROWS[i][3:0]}, {1'b0, local_oe});
			rd(ROWS[i][23:16], ROWS[i][15:8]);
		end
		$display("test local outputs done");
		wr(ADDR_COLOUR, 8'h00);
		chk_pin("oe no mode", 5'h00, {1'b0, local_oe});
		wr(ADDR_COLOUR, 8'h04);
		$display("test mode gate done");
		wr(ADDR_LANE3, 8'h03);
		wr(ADDR_LANE12, 8'h53);
		wr(ADDR_LANE0, 8'h95);
		rcfg = {4'h5, 4'h3, 4'h5, 4'h3};
		lane_in = 4'hf;
		repeat (2) @(negedge clk);
		chk_pin("fwd", 5'h1a, fwd);
		chk_pin("remote", 5'h0a, {1'b0, rem_out});
		lane_in = 4'h5;
		@(negedge clk);
		chk_pin("fwd", 5'h10, fwd);
		rem_in <= 4'hf;
		send <= 1'b1;
		@(negedge clk);
		send <= 1'b0;
		repeat (2) @(negedge clk);
		chk_pin("lane_oe", 5'h05, {1'b0, lane_oe});
		chk_pin("lane_out", 5'h05, {1'b0, lane_out & 4'h5});
		rem_in <= 4'h0;
		repeat (3) @(negedge clk);
		chk_pin("lane_hold", 5'h05, {1'b0, lane_out & 4'h5});
		wr(ADDR_LANE0, 8'h93);
		chk_pin("fwd lane0", 5'h11, fwd);
		chk_pin("lane_oe", 5'h04, {1'b0, lane_oe});
		$display("test gpio lanes done");
		wr(ADDR_LANE3, 8'h33);
		wr(ADDR_OUT56, 8'h03);
		rcfg = {4'h5, 4'h3, 4'h5, 4'h5};
		local_in = 2'b11;
		lane_in = 4'h0;
		repeat (2) @(negedge clk);
		chk_pin("fwd local", 5'h13, fwd);
		chk_pin("local_oe", 5'h08, {1'b0, local_oe});
		chk_pin("remote", 5'h03, {1'b0, rem_out});
		$display("test local inputs done");
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk_pin("fwd rst", 5'h00, fwd);
		chk_pin("oe rst", 5'h00, {1'b0, local_oe | lane_oe});
		rst = 1'b0;
		rd(ADDR_LANE3, 8'h00);
		$display("test reset done");
		report_and_stop();
	end
endmodule
